// [src/scan_test_ops.sv]
// Summary of operation
// RULE1: Toggle-outputs instruction selects the bypass bit, which captures 0 in Capture-DR.
// RULE2: Toggle-outputs inverts output cells on rising edges in idle, latched on falling.
// RULE3: Toggle-outputs leaves input cells unchanged and captures no pin values.
// RULE4: Toggle-outputs instruction puts the device in test mode.
// RULE5: Select-register scan puts that register in path; capture leaves it unchanged.
// RULE6: Controller scans the select register before issuing the run-test instruction.
// RULE7: Select bits decode X00, X01, X10, 011, 111 into the five operations.
// RULE8: Selected operation runs only under run-test instruction in Run-Test/Idle.
// RULE9: Control cells 47 to 36 never take part in pattern algorithms.
// RULE10: Enable cells 47 to 44 decide whether each pin drives or floats.
// RULE11: Operations run only with both bytes in one common direction, else bypass.
// RULE12: Sample/toggle captures input-mode pins into their cells every rising edge.
// RULE13: Sample/toggle inverts output cells on rising edges, latched to pins on falling.
// RULE14: 36-bit generation advances an LFSR rising, shown on output pins falling.
// RULE15: Controller should scan a seed into the chain before generation or compression.
// RULE16: An all-zero seed keeps the generator at zero.
// RULE17: 36-bit compression folds input pins into a 36-bit signature each rising edge.
// RULE18: During 36-bit compression output shadows hold and keep driving pins.
// RULE19: Combined 18-bit modes compress input pins into an 18-bit signature.
// RULE20: Compress-and-generate advances an 18-bit LFSR on output cells to the pins.
// RULE21: Compress-and-count increments an 18-bit counter on output cells to the pins.
// RULE22: Opcodes carry even parity in bit 7; a bad opcode acts as bypass.
// RULE23: Feedback taps of both LFSR widths are module parameters.
`default_nettype none
module scan_test_ops
    import scan_test_pkg::*;
#(
    parameter logic [DATA_WIDTH-1:0] TAPS36 = 36'h000000801,
    parameter logic [HALF_WIDTH-1:0] TAPS18 = 18'h00081
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic test_clk,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    input wire logic [HALF_WIDTH-1:0] a_pin_in,
    output logic [HALF_WIDTH-1:0] a_pin_out,
    output logic [HALF_WIDTH-1:0] a_pin_oe,
    input wire logic [HALF_WIDTH-1:0] b_pin_in,
    output logic [HALF_WIDTH-1:0] b_pin_out,
    output logic [HALF_WIDTH-1:0] b_pin_oe,
    output logic test_mode,
    output logic test_mode_sys,
    output logic pattern_run_sys
);
    typedef struct packed {
        logic rst_meta;
        logic rst_sync;
        logic en_meta;
        logic en_sync;
        logic [HALF_WIDTH-1:0] a_meta;
        logic [HALF_WIDTH-1:0] a_sync;
        logic [HALF_WIDTH-1:0] b_meta;
        logic [HALF_WIDTH-1:0] b_sync;
        tap_state_t tap;
        logic [IR_WIDTH-1:0] ir_shift;
        logic bypass;
        logic [SELECT_WIDTH-1:0] test_operation_select;
        logic [CHAIN_WIDTH-1:0] chain;
        logic shadow_copy;
        logic stepped;
    } tck_t;

    typedef struct packed {
        logic [IR_WIDTH-1:0] ir;
        logic [CHAIN_WIDTH-1:0] shadow;
        logic tdo;
        logic tdo_oe;
        logic [HALF_WIDTH-1:0] a_oe;
        logic [HALF_WIDTH-1:0] b_oe;
        logic test_mode;
        logic pattern_run;
    } neg_t;

    typedef struct packed {
        logic tm_meta;
        logic tm_sync;
        logic run_meta;
        logic run_sync;
    } ref_t;

    tck_t cur;
    tck_t next_cur;
    neg_t neg;
    neg_t next_neg;
    ref_t rs;
    ref_t next_rs;

    logic parity_ok;
    logic is_toggle;
    logic is_run;
    logic sel_select;
    logic sel_chain;
    logic dir_ok;
    logic a_is_input;
    logic toggle_idle;
    logic next_tm;
    logic [DATA_WIDTH-1:0] out_mask;
    logic [DATA_WIDTH-1:0] step_next;
    op_t active_op;

    function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
        tap_state_t n;
        n = ST_RESET;
        unique case (s)
            ST_RESET: n = m ? ST_RESET : ST_IDLE;
            ST_IDLE: n = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: n = m ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: n = m ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: n = m ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: n = m ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: n = m ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: n = m ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: n = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: n = m ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: n = m ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: n = m ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: n = m ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: n = m ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: n = m ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: n = m ? ST_SEL_DR : ST_IDLE;
            default: n = ST_RESET;
        endcase
        return n;
    endfunction

    function automatic logic is_test_instr(input logic [IR_WIDTH-1:0] op);
        is_test_instr = (~^op) && (op == OPC_RUN_TEST || op == OPC_TOGGLE_OUT ||
                        op == OPC_SEL_SCAN_TEST || op == OPC_CHAIN_READ_TEST); // see RULE4, see RULE22
    endfunction

    // Odd-parity opcodes fall back to bypass
    assign parity_ok = ~^neg.ir; // see RULE22
    assign is_toggle = parity_ok && neg.ir == OPC_TOGGLE_OUT;
    assign is_run = parity_ok && neg.ir == OPC_RUN_TEST;
    assign sel_select = parity_ok && (neg.ir == OPC_SEL_SCAN_NORMAL || neg.ir == OPC_SEL_SCAN_TEST); // see RULE5
    assign sel_chain = parity_ok && (neg.ir == OPC_CHAIN_READ_NORMAL || neg.ir == OPC_CHAIN_READ_TEST);
    assign dir_ok = (neg.shadow[BIT_AB_EN1] == neg.shadow[BIT_BA_EN_N1]) &&
                    (neg.shadow[BIT_AB_EN2] == neg.shadow[BIT_BA_EN_N2]) &&
                    (neg.shadow[BIT_AB_EN1] == neg.shadow[BIT_AB_EN2]); // see RULE11
    assign a_is_input = neg.shadow[BIT_AB_EN1];
    assign out_mask = {{BYTE_WIDTH{~neg.shadow[BIT_BA_EN_N1]}}, {BYTE_WIDTH{~neg.shadow[BIT_BA_EN_N2]}},
                       {BYTE_WIDTH{neg.shadow[BIT_AB_EN1]}}, {BYTE_WIDTH{neg.shadow[BIT_AB_EN2]}}}; // see RULE10
    assign toggle_idle = is_toggle && cur.tap == ST_IDLE;

    always_comb begin
        active_op = OP_NONE;
        if (cur.tap == ST_IDLE && is_run && dir_ok) begin // see RULE8, see RULE11
            if (cur.test_operation_select == SEL_COMP_GEN18) begin // see RULE7
                active_op = OP_COMP_GEN18;
            end else if (cur.test_operation_select == SEL_COMP_COUNT18) begin
                active_op = OP_COMP_COUNT18;
            end else if (cur.test_operation_select[1:0] == SEL_LOW_TOGGLE) begin
                active_op = OP_SAMPLE_TOGGLE;
            end else if (cur.test_operation_select[1:0] == SEL_LOW_GEN36) begin
                active_op = OP_GENERATE36;
            end else begin
                active_op = OP_COMPRESS36;
            end
        end
    end

    pattern_step #(
        .TAPS36(TAPS36),
        .TAPS18(TAPS18)
    ) u_step (
        .op(active_op),
        .a_is_input(a_is_input),
        .cells(cur.chain[DATA_WIDTH-1:0]),
        .pins({cur.a_sync, cur.b_sync}),
        .next_cells(step_next)
    );

    always_comb begin
        next_cur = cur;
        next_cur.rst_meta = sys_rst;
        next_cur.rst_sync = cur.rst_meta;
        next_cur.en_meta = clk_en;
        next_cur.en_sync = cur.en_meta;
        next_cur.a_meta = a_pin_in;
        next_cur.a_sync = cur.a_meta;
        next_cur.b_meta = b_pin_in;
        next_cur.b_sync = cur.b_meta;
        if (cur.rst_sync) begin
            next_cur.tap = ST_RESET;
            next_cur.ir_shift = IR_CAPTURE_VALUE;
            next_cur.bypass = 1'b0;
            next_cur.test_operation_select = SELECT_RESET;
            next_cur.chain = CHAIN_RESET;
            next_cur.shadow_copy = 1'b0;
            next_cur.stepped = 1'b0;
        end else if (cur.en_sync) begin
            next_cur.tap = tap_next(cur.tap, tms);
            next_cur.shadow_copy = toggle_idle || (active_op != OP_NONE && active_op != OP_COMPRESS36); // see RULE18
            next_cur.stepped = toggle_idle || active_op != OP_NONE;
            if (cur.tap == ST_CAP_IR) begin
                next_cur.ir_shift = IR_CAPTURE_VALUE;
            end
            if (cur.tap == ST_SHIFT_IR) begin
                next_cur.ir_shift = {tdi, cur.ir_shift[IR_WIDTH-1:1]};
            end
            // Select register and chain keep their contents in capture
            if (cur.tap == ST_CAP_DR) begin
                next_cur.bypass = 1'b0; // see RULE1
            end
            if (cur.tap == ST_SHIFT_DR) begin
                if (sel_chain) begin
                    next_cur.chain = {tdi, cur.chain[CHAIN_WIDTH-1:1]};
                end else if (sel_select) begin
                    next_cur.test_operation_select = {tdi, cur.test_operation_select[SELECT_WIDTH-1:1]}; // see RULE5
                end else begin
                    next_cur.bypass = tdi; // see RULE1
                end
            end
            // Only data cells move; control cells stay put
            if (toggle_idle) begin
                next_cur.chain[DATA_WIDTH-1:0] = cur.chain[DATA_WIDTH-1:0] ^ out_mask; // see RULE2, see RULE3, see RULE9
            end else if (active_op != OP_NONE) begin
                next_cur.chain[DATA_WIDTH-1:0] = step_next; // see RULE9, see RULE14
            end
        end
    end

    always_ff @(posedge test_clk) begin
        cur <= next_cur;
    end

    always_comb begin
        next_neg = neg;
        next_tm = is_test_instr(neg.ir);
        if (cur.rst_sync) begin
            next_neg.ir = OPC_BYPASS;
            next_neg.shadow = CHAIN_RESET;
            next_neg.tdo = 1'b0;
            next_neg.tdo_oe = 1'b0;
            next_neg.a_oe = '0;
            next_neg.b_oe = '0;
            next_neg.test_mode = 1'b0;
            next_neg.pattern_run = 1'b0;
        end else if (cur.en_sync) begin
            if (cur.tap == ST_RESET) begin
                next_neg.ir = OPC_BYPASS;
            end else if (cur.tap == ST_UPD_IR) begin
                next_neg.ir = cur.ir_shift;
            end
            if (cur.tap == ST_UPD_DR && sel_chain) begin
                next_neg.shadow = cur.chain;
            end else if (cur.shadow_copy) begin
                next_neg.shadow[DATA_WIDTH-1:0] = (neg.shadow[DATA_WIDTH-1:0] & ~out_mask) |
                                                  (cur.chain[DATA_WIDTH-1:0] & out_mask); // see RULE2, see RULE13
            end
            if (cur.tap == ST_SHIFT_IR) begin
                next_neg.tdo = cur.ir_shift[0];
            end else if (sel_chain) begin
                next_neg.tdo = cur.chain[0];
            end else if (sel_select) begin
                next_neg.tdo = cur.test_operation_select[0];
            end else begin
                next_neg.tdo = cur.bypass;
            end
            next_neg.tdo_oe = cur.tap == ST_SHIFT_IR || cur.tap == ST_SHIFT_DR;
            next_tm = is_test_instr(next_neg.ir);
            next_neg.test_mode = next_tm; // see RULE4
            // Pins drive only in test mode, per byte as the enable cells say
            next_neg.a_oe = next_tm ? {{BYTE_WIDTH{~next_neg.shadow[BIT_BA_EN_N1]}},
                                       {BYTE_WIDTH{~next_neg.shadow[BIT_BA_EN_N2]}}} : '0; // see RULE10
            next_neg.b_oe = next_tm ? {{BYTE_WIDTH{next_neg.shadow[BIT_AB_EN1]}},
                                       {BYTE_WIDTH{next_neg.shadow[BIT_AB_EN2]}}} : '0; // see RULE10
            next_neg.pattern_run = cur.stepped;
        end
    end

    always_ff @(negedge test_clk) begin
        neg <= next_neg;
    end

    // Levels only cross; a multi-bit status would need a handshake
    always_comb begin
        next_rs = rs;
        if (sys_rst) begin
            next_rs = '0;
        end else if (clk_en) begin
            next_rs.tm_meta = neg.test_mode;
            next_rs.tm_sync = rs.tm_meta;
            next_rs.run_meta = neg.pattern_run;
            next_rs.run_sync = rs.run_meta;
        end
    end

    always_ff @(posedge ref_clk) begin
        rs <= next_rs;
    end

    assign tdo = neg.tdo;
    assign tdo_oe = neg.tdo_oe;
    assign a_pin_out = neg.shadow[A_LSB+HALF_WIDTH-1:A_LSB];
    assign b_pin_out = neg.shadow[B_LSB+HALF_WIDTH-1:B_LSB];
    assign a_pin_oe = neg.a_oe;
    assign b_pin_oe = neg.b_oe;
    assign test_mode = neg.test_mode;
    assign test_mode_sys = rs.tm_sync;
    assign pattern_run_sys = rs.run_sync;

    logic [HALF_WIDTH-1:0] out_half_now;
    assign out_half_now = a_is_input ? cur.chain[B_LSB+HALF_WIDTH-1:B_LSB] : cur.chain[A_LSB+HALF_WIDTH-1:A_LSB];

    a_bypass_capture: assert property (@(posedge test_clk) disable iff (cur.rst_sync) // see RULE1
        (cur.tap == ST_CAP_DR && is_toggle && cur.en_sync) |=> !cur.bypass)
        else $error("bypass bit not cleared in capture");
    a_toggle_outputs: assert property (@(posedge test_clk) disable iff (cur.rst_sync) // see RULE2
        (toggle_idle && cur.en_sync) |=> (cur.chain[DATA_WIDTH-1:0] & $past(out_mask)) ==
            (~$past(cur.chain[DATA_WIDTH-1:0]) & $past(out_mask)))
        else $error("output cells not inverted");
    a_toggle_inputs_hold: assert property (@(posedge test_clk) disable iff (cur.rst_sync) // see RULE3
        (toggle_idle && cur.en_sync) |=> (cur.chain[DATA_WIDTH-1:0] & ~$past(out_mask)) ==
            ($past(cur.chain[DATA_WIDTH-1:0]) & ~$past(out_mask)))
        else $error("input cells changed under toggle");
    a_toggle_test_mode: assert property (@(posedge test_clk) disable iff (cur.rst_sync) // see RULE4
        is_toggle |-> neg.test_mode)
        else $error("toggle instruction outside test mode");
    a_select_capture_hold: assert property (@(posedge test_clk) disable iff (cur.rst_sync) // see RULE5
        (cur.tap == ST_CAP_DR) |=> $stable(cur.test_operation_select))
        else $error("select register changed in capture");
    a_decode_count: assert property (@(posedge test_clk) disable iff (cur.rst_sync) // see RULE7
        (cur.tap == ST_IDLE && is_run && dir_ok && cur.test_operation_select == SEL_COMP_COUNT18)
            |-> active_op == OP_COMP_COUNT18)
        else $error("count mode not decoded");
    a_op_gated: assert property (@(posedge test_clk) disable iff (cur.rst_sync) // see RULE8
        (cur.tap != ST_IDLE || !is_run) |-> active_op == OP_NONE)
        else $error("operation ran outside idle run-test");
    a_ctrl_cells_hold: assert property (@(posedge test_clk) disable iff (cur.rst_sync) // see RULE9
        (cur.tap == ST_IDLE) |=> cur.chain[CHAIN_WIDTH-1:CTRL_LSB] == $past(cur.chain[CHAIN_WIDTH-1:CTRL_LSB]))
        else $error("control cells moved in idle");
    a_bad_dir_bypass: assert property (@(posedge test_clk) disable iff (cur.rst_sync) // see RULE11
        (is_run && !dir_ok) |-> active_op == OP_NONE)
        else $error("operation ran with mixed direction");
    a_zero_seed_stays: assert property (@(posedge test_clk) disable iff (cur.rst_sync) // see RULE16
        (active_op == OP_GENERATE36 && cur.chain[DATA_WIDTH-1:0] == '0 && cur.en_sync)
            |=> cur.chain[DATA_WIDTH-1:0] == '0)
        else $error("zero seed produced a pattern");
    a_count_step: assert property (@(posedge test_clk) disable iff (cur.rst_sync) // see RULE21
        (active_op == OP_COMP_COUNT18 && cur.en_sync) |=> out_half_now == $past(out_half_now) + COUNT_STEP)
        else $error("counter did not increment");
    a_parity_bypass: assert property (@(posedge test_clk) disable iff (cur.rst_sync) // see RULE22
        !parity_ok |-> (!neg.test_mode && active_op == OP_NONE))
        else $error("odd-parity opcode acted");

    c_toggle_run: cover property (@(posedge test_clk) disable iff (cur.rst_sync) toggle_idle && cur.en_sync);
    c_generate36: cover property (@(posedge test_clk) disable iff (cur.rst_sync) active_op == OP_GENERATE36);
    c_compress36: cover property (@(posedge test_clk) disable iff (cur.rst_sync) active_op == OP_COMPRESS36);
    c_count18: cover property (@(posedge test_clk) disable iff (cur.rst_sync) active_op == OP_COMP_COUNT18);
endmodule
`default_nettype wire

// [src/scan_test_pkg.sv]
`default_nettype none
package scan_test_pkg;
    localparam int IR_WIDTH = 8;
    localparam int CHAIN_WIDTH = 48;
    localparam int DATA_WIDTH = 36;
    localparam int HALF_WIDTH = 18;
    localparam int BYTE_WIDTH = 9;
    localparam int SELECT_WIDTH = 3;

    localparam logic [IR_WIDTH-1:0] IR_CAPTURE_VALUE = 8'h81;
    localparam logic [IR_WIDTH-1:0] OPC_BYPASS = 8'hff;
    localparam logic [IR_WIDTH-1:0] OPC_RUN_TEST = 8'h09;
    localparam logic [IR_WIDTH-1:0] OPC_TOGGLE_OUT = 8'h8d;
    localparam logic [IR_WIDTH-1:0] OPC_SEL_SCAN_NORMAL = 8'h8e;
    localparam logic [IR_WIDTH-1:0] OPC_SEL_SCAN_TEST = 8'h0f;
    localparam logic [IR_WIDTH-1:0] OPC_CHAIN_READ_NORMAL = 8'h0a;
    localparam logic [IR_WIDTH-1:0] OPC_CHAIN_READ_TEST = 8'h8b;

    localparam int BIT_AB_EN1 = 47;
    localparam int BIT_AB_EN2 = 46;
    localparam int BIT_BA_EN_N1 = 45;
    localparam int BIT_BA_EN_N2 = 44;
    localparam int CTRL_LSB = 36;
    localparam int A_LSB = 18;
    localparam int B_LSB = 0;

    localparam logic [1:0] SEL_LOW_TOGGLE = 2'h0;
    localparam logic [1:0] SEL_LOW_GEN36 = 2'h1;
    localparam logic [1:0] SEL_LOW_COMP36 = 2'h2;
    localparam logic [SELECT_WIDTH-1:0] SEL_COMP_GEN18 = 3'h3;
    localparam logic [SELECT_WIDTH-1:0] SEL_COMP_COUNT18 = 3'h7;

    localparam logic [SELECT_WIDTH-1:0] SELECT_RESET = 3'h0;
    localparam logic [CHAIN_WIDTH-1:0] CHAIN_RESET = 48'h0;
    localparam logic [HALF_WIDTH-1:0] COUNT_STEP = 18'h00001;

    typedef enum logic [15:0] {
        ST_RESET = 16'h0001, ST_IDLE = 16'h0002, ST_SEL_DR = 16'h0004, ST_CAP_DR = 16'h0008,
        ST_SHIFT_DR = 16'h0010, ST_EXIT1_DR = 16'h0020, ST_PAUSE_DR = 16'h0040, ST_EXIT2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100, ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SHIFT_IR = 16'h0800,
        ST_EXIT1_IR = 16'h1000, ST_PAUSE_IR = 16'h2000, ST_EXIT2_IR = 16'h4000, ST_UPD_IR = 16'h8000
    } tap_state_t;

    typedef enum logic [5:0] {
        OP_NONE = 6'h01,
        OP_SAMPLE_TOGGLE = 6'h02,
        OP_GENERATE36 = 6'h04,
        OP_COMPRESS36 = 6'h08,
        OP_COMP_GEN18 = 6'h10,
        OP_COMP_COUNT18 = 6'h20
    } op_t;
endpackage
`default_nettype wire

// [src/pattern_step.sv]
`default_nettype none
module pattern_step
    import scan_test_pkg::*;
#(
    parameter logic [DATA_WIDTH-1:0] TAPS36 = 36'h000000801,
    parameter logic [HALF_WIDTH-1:0] TAPS18 = 18'h00081
) (
    input wire op_t op,
    input wire logic a_is_input,
    input wire logic [DATA_WIDTH-1:0] cells,
    input wire logic [DATA_WIDTH-1:0] pins,
    output logic [DATA_WIDTH-1:0] next_cells
);
    logic [HALF_WIDTH-1:0] in_half;
    logic [HALF_WIDTH-1:0] out_half;
    logic [HALF_WIDTH-1:0] in_pins;
    logic [HALF_WIDTH-1:0] next_in;
    logic [HALF_WIDTH-1:0] next_out;
    logic [DATA_WIDTH-1:0] in_vec;

    // Plain xor feedback: an all-zero register can never leave zero
    function automatic logic [HALF_WIDTH-1:0] lfsr18(input logic [HALF_WIDTH-1:0] x);
        lfsr18 = {x[HALF_WIDTH-2:0], ^(x & TAPS18)}; // see RULE23
    endfunction

    always_comb begin
        in_half = a_is_input ? cells[A_LSB+HALF_WIDTH-1:A_LSB] : cells[B_LSB+HALF_WIDTH-1:B_LSB];
        out_half = a_is_input ? cells[B_LSB+HALF_WIDTH-1:B_LSB] : cells[A_LSB+HALF_WIDTH-1:A_LSB];
        in_pins = a_is_input ? pins[A_LSB+HALF_WIDTH-1:A_LSB] : pins[B_LSB+HALF_WIDTH-1:B_LSB];
        in_vec = a_is_input ? {in_pins, {HALF_WIDTH{1'b0}}} : {{HALF_WIDTH{1'b0}}, in_pins};
        next_in = in_half;
        next_out = out_half;
        next_cells = cells;
        unique case (op)
            OP_NONE: begin
            end
            OP_SAMPLE_TOGGLE: begin
                next_in = in_pins; // see RULE12
                next_out = ~out_half; // see RULE13
            end
            OP_GENERATE36: begin
                next_cells = {cells[DATA_WIDTH-2:0], ^(cells & TAPS36)}; // see RULE14, see RULE16, see RULE23
            end
            OP_COMPRESS36: begin
                next_cells = {cells[DATA_WIDTH-2:0], ^(cells & TAPS36)} ^ in_vec; // see RULE17
            end
            OP_COMP_GEN18: begin
                next_in = lfsr18(in_half) ^ in_pins; // see RULE19
                next_out = lfsr18(out_half); // see RULE20
            end
            OP_COMP_COUNT18: begin
                next_in = lfsr18(in_half) ^ in_pins; // see RULE19
                next_out = out_half + COUNT_STEP; // see RULE21
            end
        endcase
        if (op == OP_SAMPLE_TOGGLE || op == OP_COMP_GEN18 || op == OP_COMP_COUNT18) begin
            next_cells = a_is_input ? {next_in, next_out} : {next_out, next_in};
        end
    end
endmodule
`default_nettype wire

// [tb/tap_ctrl.sv]
`default_nettype none
module tap_ctrl (
    input wire logic test_clk,
    input wire logic tdo,
    input wire logic tdo_oe,
    output logic tms,
    output logic tdi
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        tms = 1'b1;
        tdi = 1'b0;
    end
    // Change on the falling edge so the device's rising-edge sample sees settled levels
    task automatic step(input logic m, input logic d, output logic q);
        @(negedge test_clk);
        tms <= m;
        tdi <= d;
        @(posedge test_clk);
        // Released line reads inverted, so a missing enable shows as wrong data
        q = tdo_oe ? tdo : ~tdo;
    endtask
    // Idle to Idle; bits go LSB first, the last one with tms high
    task automatic scan(input logic ir, input int n, input logic [47:0] din, output logic [47:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b0, q);
        if (ir) step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, ~din[n-1], q);
        step(1'b0, din[n-1], q);
    endtask
endmodule
`default_nettype wire

// [tb/tb_boundary_scan_test_operations.sv]
`default_nettype none
module tb_boundary_scan_test_operations;
    import scan_test_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // Not the defaults, so a hard-wired tap set shows up
    localparam logic [35:0] T36 = 36'h0000a0011;
    localparam logic [17:0] T18 = 18'h20041;
    logic ref_clk = 1'b0, test_clk = 1'b0, sys_rst = 1'b1, tms, tdi, tdo, tdo_oe, test_mode, tm_sys, run_sys;
    logic [17:0] a_pin_in = 18'h0, b_pin_in = 18'h0, a_out, a_oe, b_out, b_oe;
    logic [2:0] last_sel = 3'h0;
    logic [47:0] q;
    int fails = 0, n_compared = 0;
    int ops[9] = '{0, 1, 2, 3, 7, 4, 5, 6, 8};
    always #12.5 ref_clk = ~ref_clk;
    always #80 test_clk = ~test_clk;
    scan_test_ops #(.TAPS36(T36), .TAPS18(T18)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1),
        .test_clk(test_clk), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .a_pin_in(a_pin_in),
        .a_pin_out(a_out), .a_pin_oe(a_oe), .b_pin_in(b_pin_in), .b_pin_out(b_out), .b_pin_oe(b_oe),
        .test_mode(test_mode), .test_mode_sys(tm_sys), .pattern_run_sys(run_sys));
    tap_ctrl pc (.test_clk(test_clk), .tdo(tdo), .tdo_oe(tdo_oe), .tms(tms), .tdi(tdi));
    task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic ir(input logic [7:0] op);
        pc.scan(1'b1, 8, {40'h0, op}, q);
        chk("ir capture", 48'h81, q);
        chk("tdo released", 48'h0, tdo_oe);
    endtask
    // One step of the chain model; s of 8 stands for the toggle-outputs instruction
    function automatic logic [35:0] nxt(logic [35:0] x, int s, logic d, logic [17:0] pi);
        logic [17:0] i, o;
        i = d ? x[35:18] : x[17:0];
        o = d ? x[17:0] : x[35:18];
        if (s[1:0] == 2'b01 && s != 8) return {x[34:0], ^(x & T36)};
        if (s[1:0] == 2'b10) return {x[34:0], ^(x & T36)} ^ (d ? {pi, 18'h0} : {18'h0, pi});
        if (s == 8) o = ~o;
        else if (s[1:0] == 2'b00) begin
            i = pi;
            o = ~o;
        end else begin
            i = {i[16:0], ^(i & T18)} ^ pi;
            o = s[2] ? o + 18'h1 : {o[16:0], ^(o & T18)};
        end
        return d ? {i, o} : {o, i};
    endfunction
    task automatic run(input int s, input logic [35:0] seed, input logic [3:0] en);
        logic [35:0] x, xp;
        logic [17:0] ra, rb, pi;
        logic [11:0] ctrl;
        logic d, ok;
        int n;
        ctrl = {en, 8'($urandom)};
        d = en[3];
        ok = en == 4'hf || en == 4'h0;
        n = 2 + $urandom_range(0, 9);
        ra = 18'($urandom);
        rb = 18'($urandom);
        pi = d ? ra : rb;
        @(posedge ref_clk);
        a_pin_in <= ra;
        b_pin_in <= rb;
        ir(OPC_SEL_SCAN_TEST);
        pc.scan(1'b0, 3, 48'(s[2:0]), q);
        chk("select readback", 48'(last_sel), q);
        last_sel = s[2:0];
        ir(OPC_CHAIN_READ_TEST);
        pc.scan(1'b0, 48, {ctrl, seed}, q);
        if (ok) chk("drive enables", d ? 36'h3ffff : 36'hffffc0000, {a_oe, b_oe});
        ir(s == 8 ? OPC_TOGGLE_OUT : OPC_RUN_TEST);
        chk("test mode", 48'h1, test_mode);
        idle(n);
        x = seed;
        xp = seed;
        for (int k = 0; k <= n; k++) begin
            if (k == n - 1) xp = x;
            if (ok) x = nxt(x, s, d, pi);
        end
        // Pins lag the chain by one falling edge
        if (s[1:0] != 2'b10 && ok) xp = d ? {seed[35:18], xp[17:0]} : {xp[35:18], seed[17:0]};
        else xp = seed;
        chk("pin values", 48'(xp), {a_out, b_out});
        if (s != 8) chk("run flag", 48'(ok), run_sys);
        chk("test mode sync", 48'h1, tm_sys);
        ir(OPC_CHAIN_READ_TEST);
        pc.scan(1'b0, 48, 48'h0, q);
        chk("chain", {ctrl, x}, q);
        $display("test op %0d dir %0d done", s, d);
    endtask
    task automatic idle(input int n);
        logic b;
        repeat (n) pc.step(1'b0, 1'b0, b);
    endtask
    initial begin
        #2000000;
        fails++;
        give_verdict();
    end
    initial begin
        void'($urandom(8));
        repeat (5) @(posedge test_clk);
        chk("reset outputs", 48'h0, {test_mode, a_oe, b_oe});
        @(posedge ref_clk);
        sys_rst <= 1'b0;
        // Reset reaches the test logic two edges late; the third edge leaves reset
        idle(3);
        foreach (ops[i]) run(ops[i], 36'({$urandom, $urandom}), ($urandom & 1) ? 4'hf : 4'h0);
        run(1, 36'h0, 4'hf);
        run(2, 36'({$urandom, $urandom}), 4'hc);
        ir(OPC_TOGGLE_OUT);
        pc.scan(1'b0, 2, 48'h3, q);
        chk("bypass capture", 48'h2, {46'h0, q[1:0]});
        ir(8'h89);
        chk("odd parity mode", 48'h0, test_mode);
        give_verdict();
    end
endmodule
`default_nettype wire
